// ==== verilog/pcmc_defines.svh ====
// Offsets, mode codes, reset values and timing counts for the channel mode control.
// Assumes the includer works at a 250 MHz core clock.
`ifndef PCMC_DEFINES_SVH
`define PCMC_DEFINES_SVH

`define PCMC_OFS_POWER_EVENT   8'h02
`define PCMC_OFS_FAULT_EVENT   8'h06
`define PCMC_OFS_POWER_STATUS  8'h10
`define PCMC_OFS_OPMODE        8'h12
`define PCMC_OFS_DCDIS_EN      8'h13
`define PCMC_OFS_DETCLS_EN     8'h14
`define PCMC_OFS_RESTART       8'h18
`define PCMC_OFS_POWER_CMD     8'h19
`define PCMC_OFS_POLICE_EN     8'h1E
`define PCMC_OFS_FOLDBACK      8'h40

`define PCMC_RST_OPMODE        8'h00
`define PCMC_RST_DCDIS_EN      8'h0F
`define PCMC_RST_DETCLS_EN     8'h00
`define PCMC_RST_POLICE_EN     8'h00
`define PCMC_RST_FOLDBACK      8'h00

`define PCMC_MODE_OFF          2'h0
`define PCMC_MODE_MANUAL       2'h1
`define PCMC_MODE_SEMI         2'h2
`define PCMC_MODE_AUTO         2'h3

`define PCMC_CLK_MHZ           250
`define PCMC_HOLD_US           3000
`define PCMC_CLEAR_US          5000
`define PCMC_TDIS_US           300000
`define PCMC_TDIS_CYC          (`PCMC_TDIS_US * `PCMC_CLK_MHZ)
`define PCMC_HOLD_CYC          (`PCMC_HOLD_US * `PCMC_CLK_MHZ)
`define PCMC_CLEAR_CYC         (`PCMC_CLEAR_US * `PCMC_CLK_MHZ)
`define PCMC_CLEAR_STEP        32'd1

`endif

// ==== verilog/pcmc_pkg.sv ====
// Types shared by the channel mode control.
// Assumes pcmc_defines.svh supplies the numeric constants.
package pcmc_pkg;

	typedef enum logic [2:0] {
		CH_IDLE,
		CH_DETECT,
		CH_CLASS,
		CH_POWERED,
		CH_COOLDOWN,
		CH_CLEARING
	} pcmc_state_type;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} pcmc_cmd_type;

	typedef struct packed {
		logic       done;
		logic       valid;
		logic       grant;
	} pcmc_meas_type;

endpackage

// ==== verilog/pcmc_channel_mode_control.sv ====
// Four-channel operating mode control with register command port and DC disconnect timers.
// Assumes a decoded register command port from the serial bus front end, and analog
// measurement engines that answer detect/class requests with one-cycle done pulses.
`include "pcmc_defines.svh"
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Off mode clears only that channel's bits.
// - Off-mode clearing finishes five milliseconds after the mode leaves off.
// - Power-good/enable fall sets change events.
// - Semi to manual/off aborts cooldown.
// - Manual mode idles until explicit command.
// - Manual enable launches exactly one cycle.
// - Power-on command turns channel on immediately.
// - Manual power-on assigns no class; host configures.
// - Semi: detect clear idles; enables choose cycling.
// - Semi cycles repeat; class only after valid detect.
// - Auto powers on after valid signature, allocation.
// - Auto idles until both enables or power-on.
// - Auto turn-on loads policing and foldback settings.
// - Disconnect timeout turns off, sets fault flag.
// - Timer resets after 3 ms above threshold.
// - Disconnect enable low nibble resets to one.
// - Enables during cooldown wait until it ends.
// - Class enables high nibble, detect low; reset zero.
// - Manual enables self-clear; a manual power-off command clears them.
// - Restart write sets enables but, unlike direct write, never clears.
// - Two-bit mode field per channel, reset off.
// - Off mode: unpowered, no detect or class.
module pcmc_channel_mode_control #(
	parameter int                    NCH       = 4,
	parameter int                    TDIS_CYC  = `PCMC_TDIS_CYC,
	parameter int                    HOLD_CYC  = `PCMC_HOLD_CYC,
	parameter int                    CLEAR_CYC = `PCMC_CLEAR_CYC
) (
	input  wire logic                clock_i,
	input  wire logic                sys_rst_i,
	input  wire pcmc_pkg::pcmc_cmd_type cmd_i,
	output logic [7:0]               rdata_o,
	input  wire logic [NCH-1:0]      detect_done_i,
	input  wire logic [NCH-1:0]      detect_valid_i,
	input  wire logic [NCH-1:0]      class_done_i,
	input  wire logic [NCH-1:0]      class_grant_i,
	input  wire logic [NCH-1:0]      current_low_i,
	input  wire logic [NCH-1:0]      fault_cooldown_i,
	input  wire logic [NCH-1:0]      power_good_i,
	output logic [NCH-1:0]           detect_req_o,
	output logic [NCH-1:0]           class_req_o,
	output logic [NCH-1:0]           power_enabled_state_o,
	output logic [NCH-1:0]           disconnect_fault_flag_o
);

	localparam int CW = 32;
	// Register state.
	logic [7:0]           opmode_r, opmode_nxt;
	logic [7:0]           dcdis_r, dcdis_nxt;
	logic [NCH-1:0]       detect_enable_bit_r, detect_enable_bit_nxt;
	logic [NCH-1:0]       class_enable_bit_r, class_enable_bit_nxt;
	logic [NCH-1:0]       power_good_flag_r, power_good_flag_nxt;
	logic [NCH-1:0]       pe_r, pe_nxt;
	logic [NCH-1:0]       pg_change_r, pg_change_nxt;
	logic [NCH-1:0]       pe_change_r, pe_change_nxt;
	logic [NCH-1:0]       disf_r, disf_nxt;
	logic [NCH-1:0]       police_r, police_nxt;
	logic [NCH-1:0]       fold_r, fold_nxt;
	logic [NCH-1:0]       det_req_r, det_req_nxt;
	logic [NCH-1:0]       cls_req_r, cls_req_nxt;
	logic [7:0]           rdata_r, rdata_nxt;
	pcmc_pkg::pcmc_state_type st_r [NCH];
	pcmc_pkg::pcmc_state_type st_nxt [NCH];
	logic [CW-1:0]        tdis_r [NCH];
	logic [CW-1:0]        tdis_nxt [NCH];
	logic [CW-1:0]        hold_r [NCH];
	logic [CW-1:0]        hold_nxt [NCH];

	// Next-state logic for every channel and the register file.
	always_comb begin
		logic [1:0] md;
		logic [1:0] old_md;
		logic       wr_mode;
		logic       wr_en;
		logic       wr_rst;
		logic       power_on_command;
		logic       pwoff;
		logic       turn_off;
		opmode_nxt = opmode_r;
		dcdis_nxt = dcdis_r;
		detect_enable_bit_nxt = detect_enable_bit_r;
		class_enable_bit_nxt = class_enable_bit_r;
		power_good_flag_nxt = power_good_flag_r;
		pe_nxt = pe_r;
		pg_change_nxt = pg_change_r;
		pe_change_nxt = pe_change_r;
		disf_nxt = disf_r;
		police_nxt = police_r;
		fold_nxt = fold_r;
		det_req_nxt = '0;
		cls_req_nxt = '0;
		md = `PCMC_MODE_OFF;
		old_md = `PCMC_MODE_OFF;
		wr_mode = 1'b0;
		wr_en = 1'b0;
		wr_rst = 1'b0;
		power_on_command = 1'b0;
		pwoff = 1'b0;
		turn_off = 1'b0;
		st_nxt = st_r;
		tdis_nxt = tdis_r;
		hold_nxt = hold_r;
		// Host reads of event registers clear those events, but hardware sets win.
		if (cmd_i.rd && cmd_i.addr == `PCMC_OFS_POWER_EVENT) begin
			pg_change_nxt = '0;
			pe_change_nxt = '0;
		end
		if (cmd_i.rd && cmd_i.addr == `PCMC_OFS_FAULT_EVENT) begin
			disf_nxt = '0;
		end
		if (cmd_i.wr) begin
			unique case (cmd_i.addr)
				`PCMC_OFS_OPMODE:    opmode_nxt = cmd_i.wdata;
				`PCMC_OFS_DCDIS_EN:  dcdis_nxt = cmd_i.wdata;
				`PCMC_OFS_POLICE_EN: police_nxt = cmd_i.wdata[NCH-1:0];
				`PCMC_OFS_FOLDBACK:  fold_nxt = cmd_i.wdata[NCH-1:0];
				default: ;
			endcase
		end
		for (int i = 0; i < NCH; i++) begin
			md = opmode_nxt[2*i +: 2];
			old_md = opmode_r[2*i +: 2];
			wr_mode = md != old_md;
			wr_en = cmd_i.wr && cmd_i.addr == `PCMC_OFS_DETCLS_EN;
			wr_rst = cmd_i.wr && cmd_i.addr == `PCMC_OFS_RESTART
				&& (cmd_i.wdata[i] || cmd_i.wdata[i+NCH]);
			power_on_command = cmd_i.wr && cmd_i.addr == `PCMC_OFS_POWER_CMD && cmd_i.wdata[i];
			pwoff = cmd_i.wr && cmd_i.addr == `PCMC_OFS_POWER_CMD && cmd_i.wdata[i+NCH];
			turn_off = 1'b0;
			if (wr_en) begin
				detect_enable_bit_nxt[i] = cmd_i.wdata[i];
				class_enable_bit_nxt[i] = cmd_i.wdata[i+NCH];
			end
			if (wr_rst) begin
				detect_enable_bit_nxt[i] = detect_enable_bit_nxt[i] | cmd_i.wdata[i];
				class_enable_bit_nxt[i] = class_enable_bit_nxt[i] | cmd_i.wdata[i+NCH];
			end
			if (pwoff && md == `PCMC_MODE_MANUAL) begin
				detect_enable_bit_nxt[i] = 1'b0;
				class_enable_bit_nxt[i] = 1'b0;
			end
			// Power-good follows the analog comparator only while the channel is on.
			power_good_flag_nxt[i] = pe_r[i] & power_good_i[i];
			if (md == `PCMC_MODE_OFF) begin
				if (wr_mode) begin
					st_nxt[i] = pcmc_pkg::CH_CLEARING;
					hold_nxt[i] = '0;
				end
				turn_off = pe_r[i];
				detect_enable_bit_nxt[i] = 1'b0;
				class_enable_bit_nxt[i] = 1'b0;
			end else if (wr_mode && old_md == `PCMC_MODE_SEMI
				&& st_r[i] == pcmc_pkg::CH_COOLDOWN) begin
				st_nxt[i] = pcmc_pkg::CH_IDLE;
			end else if (power_on_command && st_r[i] != pcmc_pkg::CH_POWERED) begin
				st_nxt[i] = pcmc_pkg::CH_POWERED;
				pe_nxt[i] = 1'b1;
				tdis_nxt[i] = '0;
				hold_nxt[i] = '0;
			end else if (pwoff && pe_r[i]) begin
				turn_off = 1'b1;
			end else begin
				unique case (st_r[i])
					pcmc_pkg::CH_IDLE: begin
						if (fault_cooldown_i[i]) begin
							st_nxt[i] = pcmc_pkg::CH_COOLDOWN;
						end else if (md == `PCMC_MODE_MANUAL) begin
							if (detect_enable_bit_r[i]) begin
								st_nxt[i] = pcmc_pkg::CH_DETECT;
								det_req_nxt[i] = 1'b1;
							end else if (class_enable_bit_r[i]) begin
								st_nxt[i] = pcmc_pkg::CH_CLASS;
								cls_req_nxt[i] = 1'b1;
							end
						end else if (detect_enable_bit_r[i] && (md == `PCMC_MODE_SEMI
							|| class_enable_bit_r[i])) begin
							st_nxt[i] = pcmc_pkg::CH_DETECT;
							det_req_nxt[i] = 1'b1;
						end
					end
					pcmc_pkg::CH_DETECT: begin
						if (detect_done_i[i]) begin
							st_nxt[i] = pcmc_pkg::CH_IDLE;
							if (md == `PCMC_MODE_MANUAL) begin
								detect_enable_bit_nxt[i] = 1'b0;
								if (class_enable_bit_r[i]) begin
									st_nxt[i] = pcmc_pkg::CH_CLASS;
									cls_req_nxt[i] = 1'b1;
								end
							end else if (detect_valid_i[i] && class_enable_bit_r[i]) begin
								st_nxt[i] = pcmc_pkg::CH_CLASS;
								cls_req_nxt[i] = 1'b1;
							end
						end
					end
					pcmc_pkg::CH_CLASS: begin
						if (class_done_i[i]) begin
							st_nxt[i] = pcmc_pkg::CH_IDLE;
							if (md == `PCMC_MODE_MANUAL) begin
								class_enable_bit_nxt[i] = 1'b0;
							end else if (md == `PCMC_MODE_AUTO && class_grant_i[i]) begin
								st_nxt[i] = pcmc_pkg::CH_POWERED;
								pe_nxt[i] = 1'b1;
								police_nxt[i] = 1'b1;
								fold_nxt[i] = 1'b1;
								tdis_nxt[i] = '0;
								hold_nxt[i] = '0;
							end
						end
					end
					pcmc_pkg::CH_POWERED: begin
						if (dcdis_r[i] && current_low_i[i]) begin
							hold_nxt[i] = '0;
							if (tdis_r[i] >= CW'(TDIS_CYC - 1)) begin
								turn_off = 1'b1;
								disf_nxt[i] = 1'b1;
							end else begin
								tdis_nxt[i] = tdis_r[i] + 1'b1;
							end
						end else if (hold_r[i] >= CW'(HOLD_CYC - 1)) begin
							tdis_nxt[i] = '0;
						end else begin
							hold_nxt[i] = hold_r[i] + 1'b1;
						end
					end
					pcmc_pkg::CH_COOLDOWN: begin
						if (!fault_cooldown_i[i]) begin
							st_nxt[i] = pcmc_pkg::CH_IDLE;
						end
					end
					pcmc_pkg::CH_CLEARING: begin
						if (hold_r[i] >= CW'(CLEAR_CYC - 1)) begin
							st_nxt[i] = pcmc_pkg::CH_IDLE;
						end else begin
							hold_nxt[i] = hold_r[i] + `PCMC_CLEAR_STEP;
						end
					end
					default: st_nxt[i] = pcmc_pkg::CH_IDLE; // Unused codes fall back to idle.
				endcase
			end
			if (turn_off) begin
				pe_nxt[i] = 1'b0;
				power_good_flag_nxt[i] = 1'b0;
				if (st_nxt[i] == pcmc_pkg::CH_POWERED) begin
					st_nxt[i] = pcmc_pkg::CH_IDLE;
				end
				tdis_nxt[i] = '0;
			end
			if (md == `PCMC_MODE_OFF && wr_mode) begin
				police_nxt[i] = 1'b0;
				fold_nxt[i] = 1'b0;
				disf_nxt[i] = 1'b0;
			end
			// Falling power bits raise change events after any clears above.
			if (pe_r[i] && !pe_nxt[i]) begin
				pe_change_nxt[i] = 1'b1;
			end
			if (power_good_flag_r[i] && !power_good_flag_nxt[i]) begin
				pg_change_nxt[i] = 1'b1;
			end
		end
		// Read data, registered one cycle after the read strobe.
		rdata_nxt = rdata_r;
		if (cmd_i.rd) begin
			unique case (cmd_i.addr)
				`PCMC_OFS_POWER_EVENT:  rdata_nxt = {pg_change_r, pe_change_r};
				`PCMC_OFS_FAULT_EVENT:  rdata_nxt = {{(8-NCH){1'b0}}, disf_r};
				`PCMC_OFS_POWER_STATUS: rdata_nxt = {power_good_flag_r, pe_r};
				`PCMC_OFS_OPMODE:       rdata_nxt = opmode_r;
				`PCMC_OFS_DCDIS_EN:     rdata_nxt = dcdis_r;
				`PCMC_OFS_DETCLS_EN:    rdata_nxt = {class_enable_bit_r, detect_enable_bit_r};
				`PCMC_OFS_POLICE_EN:    rdata_nxt = {{(8-NCH){1'b0}}, police_r};
				`PCMC_OFS_FOLDBACK:     rdata_nxt = {{(8-NCH){1'b0}}, fold_r};
				default:                rdata_nxt = 8'h00;
			endcase
		end
	end

	// State registers.
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			opmode_r <= `PCMC_RST_OPMODE;
			dcdis_r <= `PCMC_RST_DCDIS_EN;
			detect_enable_bit_r <= '0;
			class_enable_bit_r <= '0;
			power_good_flag_r <= '0;
			pe_r <= '0;
			pg_change_r <= '0;
			pe_change_r <= '0;
			disf_r <= '0;
			police_r <= '0;
			fold_r <= '0;
			det_req_r <= '0;
			cls_req_r <= '0;
			rdata_r <= 8'h00;
			st_r <= '{default: pcmc_pkg::CH_IDLE};
			tdis_r <= '{default: '0};
			hold_r <= '{default: '0};
		end else begin
			opmode_r <= opmode_nxt;
			dcdis_r <= dcdis_nxt;
			detect_enable_bit_r <= detect_enable_bit_nxt;
			class_enable_bit_r <= class_enable_bit_nxt;
			power_good_flag_r <= power_good_flag_nxt;
			pe_r <= pe_nxt;
			pg_change_r <= pg_change_nxt;
			pe_change_r <= pe_change_nxt;
			disf_r <= disf_nxt;
			police_r <= police_nxt;
			fold_r <= fold_nxt;
			det_req_r <= det_req_nxt;
			cls_req_r <= cls_req_nxt;
			rdata_r <= rdata_nxt;
			st_r <= st_nxt;
			tdis_r <= tdis_nxt;
			hold_r <= hold_nxt;
		end
	end

	// Outputs straight from flip-flops.
	assign rdata_o = rdata_r;
	assign detect_req_o = det_req_r;
	assign class_req_o = cls_req_r;
	assign power_enabled_state_o = pe_r;
	assign disconnect_fault_flag_o = disf_r;

endmodule
`default_nettype wire

// ==== tb/pcmc_chk_asserts.sv ====
// Port assertions for the channel mode control.
// Assumes a bind to the top; mode and enables mirror bus writes.
`timescale 1ns/1ps
`default_nettype none
module pcmc_chk #(
	parameter int NCH = 4
) (
	input wire logic                   clock_i,
	input wire logic                   sys_rst_i,
	input wire pcmc_pkg::pcmc_cmd_type cmd_i,
	input wire logic [7:0]             rdata_o,
	input wire logic [NCH-1:0]         fault_cooldown_i,
	input wire logic [NCH-1:0]         detect_req_o,
	input wire logic [NCH-1:0]         class_req_o,
	input wire logic [NCH-1:0]         power_enabled_state_o,
	input wire logic [NCH-1:0]         disconnect_fault_flag_o
);
	logic [7:0]     mode_r, mode_nxt, dis_r, dis_nxt;
	logic [NCH-1:0] off_m;
	// Mirrors the mode and disconnect enable registers from writes.
	always_comb begin
		mode_nxt = (cmd_i.wr && cmd_i.addr == 8'h12) ? cmd_i.wdata : mode_r;
		dis_nxt = (cmd_i.wr && cmd_i.addr == 8'h13) ? cmd_i.wdata : dis_r;
		for (int i = 0; i < NCH; i++) begin
			off_m[i] = mode_r[2*i+:2] == 2'h0;
		end
	end
	// Registers the mirror.
	always_ff @(posedge clock_i) begin
		mode_r <= sys_rst_i ? 8'h00 : mode_nxt;
		dis_r <= sys_rst_i ? 8'h0F : dis_nxt;
	end
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);
	chk_off_quiet: assert property (
		(off_m & $past(off_m) & (detect_req_o | class_req_o | power_enabled_state_o)) == '0)
		else $error("off channel active");
	chk_rd_mode: assert property (
		cmd_i.rd && cmd_i.addr == 8'h12 |=> rdata_o == $past(mode_r))
		else $error("mode read wrong");
	chk_rd_disable: assert property (
		cmd_i.rd && cmd_i.addr == 8'h13 |=> rdata_o == $past(dis_r))
		else $error("disconnect enable read wrong");
	chk_req_single: assert property (
		(detect_req_o & $past(detect_req_o)) == '0)
		else $error("detect request too long");
	chk_cool_park: assert property (
		((detect_req_o | class_req_o) & $past(fault_cooldown_i)) == '0)
		else $error("request in cooldown");
	chk_fault_off: assert property (
		(disconnect_fault_flag_o & ~$past(disconnect_fault_flag_o) & power_enabled_state_o) == '0)
		else $error("fault without turn-off");
	chk_fault_gate: assert property (
		(disconnect_fault_flag_o & ~$past(disconnect_fault_flag_o) & ~$past(dis_r[NCH-1:0])) == '0)
		else $error("fault while disabled");
	for (genvar g = 0; g < NCH; g++) begin : g_on
		chk_power_on: assert property (
			cmd_i.wr && cmd_i.addr == 8'h19 && cmd_i.wdata[g] && !cmd_i.wdata[g+NCH]
			&& !off_m[g] && !fault_cooldown_i[g] |=> power_enabled_state_o[g])
			else $error("power-on ignored");
	end
	cov_powered: cover property (|power_enabled_state_o);
	cov_fault: cover property (|disconnect_fault_flag_o);
	cov_class: cover property (|class_req_o);
endmodule
bind pcmc_channel_mode_control pcmc_chk #(.NCH(NCH)) u_chk (
	.clock_i(clock_i), .sys_rst_i(sys_rst_i), .cmd_i(cmd_i), .rdata_o(rdata_o),
	.fault_cooldown_i(fault_cooldown_i), .detect_req_o(detect_req_o),
	.class_req_o(class_req_o), .power_enabled_state_o(power_enabled_state_o),
	.disconnect_fault_flag_o(disconnect_fault_flag_o));
`default_nettype wire

// ==== tb/pcmc_meas_model.sv ====
// Stand-in for the detection and classification engines.
// Assumes one-cycle requests; each is answered DLY cycles later.
`timescale 1ns/1ps
`default_nettype none
module pcmc_meas_model #(
	parameter int DLY = 3
) (
	input  wire logic       clock_i,
	input  wire logic [3:0] det_req_i,
	input  wire logic [3:0] cls_req_i,
	input  wire logic [3:0] det_ok_i,
	input  wire logic [3:0] cls_ok_i,
	output var  logic [3:0] det_done_o,
	output var  logic [3:0] det_valid_o,
	output var  logic [3:0] cls_done_o,
	output var  logic [3:0] cls_grant_o
);
	logic [4*DLY-1:0] dsh = '0;
	logic [4*DLY-1:0] csh = '0;
	logic             tgl = 1'b0;
	// Delays requests to done pulses; the toggle spoils stale qualifiers.
	always @(posedge clock_i) begin
		dsh <= {dsh[4*DLY-5:0], det_req_i};
		csh <= {csh[4*DLY-5:0], cls_req_i};
		tgl <= ~tgl;
	end
	// Qualifiers carry the verdict only in the done cycle.
	assign det_done_o = dsh[4*DLY-1-:4];
	assign cls_done_o = csh[4*DLY-1-:4];
	assign det_valid_o = (det_done_o & det_ok_i) | (~det_done_o & {4{tgl}});
	assign cls_grant_o = (cls_done_o & cls_ok_i) | (~cls_done_o & {4{tgl}});
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the channel mode control.
// Assumes the bound checker and the measurement model as far side.
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int TDIS = 40;
	logic          clk = 1'b0;
	logic          rst = 1'b1;
	logic [7:0]    rdata, r;
	logic [3:0]    dd, dv, cd, cg, dreq, creq, pe, flt;
	logic [3:0]    low = 4'h0, cool = 4'h0, dok = 4'hF, cok = 4'hF;
	int            n_mismatch = 0, compares = 0, cyc = 0;
	int            n_det [4], n_cls [4];
	pcmc_pkg::pcmc_cmd_type cmd = '0;
	pcmc_channel_mode_control #(.TDIS_CYC(TDIS), .HOLD_CYC(12), .CLEAR_CYC(20)) dut (
		.clock_i(clk), .sys_rst_i(rst), .cmd_i(cmd), .rdata_o(rdata),
		.detect_done_i(dd), .detect_valid_i(dv), .class_done_i(cd), .class_grant_i(cg),
		.current_low_i(low), .fault_cooldown_i(cool), .power_good_i(pe),
		.detect_req_o(dreq), .class_req_o(creq), .power_enabled_state_o(pe),
		.disconnect_fault_flag_o(flt));
	pcmc_meas_model #(.DLY(3)) u_meas (
		.clock_i(clk), .det_req_i(dreq), .cls_req_i(creq), .det_ok_i(dok),
		.cls_ok_i(cok), .det_done_o(dd), .det_valid_o(dv), .cls_done_o(cd),
		.cls_grant_o(cg));
	// Clock generator.
	initial begin
		forever #2 clk = ~clk;
	end
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Counts launched cycles and cuts a hung run short.
	always @(posedge clk) begin
		cyc++;
		for (int i = 0; i < 4; i++) begin
			n_det[i] += dreq[i];
			n_cls[i] += creq[i];
		end
		if (cyc == 8000) begin
			n_mismatch++;
			print_verdict();
		end
	end
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic clr();
		n_det = '{default: 0};
		n_cls = '{default: 0};
	endtask
	task automatic bus(input logic [7:0] a, input logic [7:0] d, input logic rd);
		cmd = '{a, d, !rd, rd};
		tick(1);
		cmd = '0;
		tick(1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		bus(a, 8'h00, 1'b1);
		chk($sformatf("reg %h", a), rdata, e);
	endtask
	task automatic wpe(input int ch, input logic v, input int lim);
		for (int k = 0; k < lim && pe[ch] !== v; k++) begin
			tick(1);
		end
		chk($sformatf("on %0d", ch), {7'h0, pe[ch]}, {7'h0, v});
	endtask
	// Main sequence: semi on 0 and 1, manual on 2, automatic on 3.
	initial begin
		void'($urandom(32'hd989));
		tick(4);
		rst = 1'b0;
		rd(8'h12, 8'h00);
		rd(8'h13, 8'h0F);
		rd(8'h14, 8'h00);
		r = 8'($urandom);
		bus(8'h13, r, 1'b0);
		rd(8'h13, r);
		bus(8'h13, 8'h0F, 1'b0);
		bus(8'h12, 8'hDA, 1'b0);
		clr();
		bus(8'h14, 8'h31, 1'b0);
		tick(60);
		chk("semi cycling", 8'(n_det[0] >= 2 && n_cls[0] >= 2), 8'h01);
		chk("semi class only", 8'(n_det[1] + n_cls[1]), 8'h00);
		chk("idle", 8'(n_det[2] + n_det[3]), 8'h00);
		dok[0] = 1'b0;
		tick(10);
		clr();
		tick(40);
		chk("class after bad detect", 8'(n_cls[0]), 8'h00);
		cool[1] = 1'b1;
		bus(8'h14, 8'h33, 1'b0);
		tick(30);
		chk("held", 8'(n_det[1]), 8'h00);
		cool[1] = 1'b0;
		tick(30);
		chk("restarted", 8'(n_det[1] >= 1), 8'h01);
		clr();
		bus(8'h14, 8'h37, 1'b0);
		tick(40);
		chk("manual once", 8'(n_det[2] * 16 + n_cls[2]), 8'h10);
		rd(8'h14, 8'h33);
		// Allocation settings load on automatic turn-on after restart enables.
		bus(8'h18, 8'h88, 1'b0);
		wpe(3, 1'b1, 60);
		rd(8'h40, 8'h08);
		rd(8'h1E, 8'h08);
		rd(8'h14, 8'hBB);
		cok[3] = 1'b0;
		low[3] = 1'b1;
		wpe(3, 1'b0, TDIS + 40);
		chk("fault", {4'h0, flt}, 8'h08);
		rd(8'h06, 8'h08);
		rd(8'h02, 8'h88);
		chk("fault read", {4'h0, flt}, 8'h00);
		bus(8'h19, 8'h04, 1'b0);
		wpe(2, 1'b1, 3);
		// A long enough high stretch between two low spells restarts the timer.
		low[2] = 1'b1;
		tick(TDIS - 10);
		low[2] = 1'b0;
		tick(16);
		low[2] = 1'b1;
		tick(TDIS - 10);
		chk("timer reset", {4'h0, pe}, 8'h04);
		// With disconnect disabled a low current never turns the channel off.
		bus(8'h13, 8'h0B, 1'b0);
		tick(TDIS + 10);
		chk("disconnect off", {pe, flt}, 8'h40);
		low[2] = 1'b0;
		bus(8'h13, 8'h0F, 1'b0);
		bus(8'h12, 8'h1A, 1'b0);
		chk("off keeps others", {pe, flt}, 8'h40);
		rd(8'h14, 8'h33);
		rd(8'h40, 8'h00);
		rd(8'h1E, 8'h00);
		bus(8'h19, 8'h08, 1'b0);
		tick(3);
		chk("off ignores on", {4'h0, pe}, 8'h04);
		bus(8'h19, 8'h40, 1'b0);
		wpe(2, 1'b0, 3);
		rd(8'h02, 8'h44);
		print_verdict();
	end
endmodule
`default_nettype wire
